// ==== common/pwm_cfg_pkg.sv ====
// Register map, field layout and constants of the PWM generator config block
package pwm_cfg_pkg;
    localparam logic [3:0]  PHASE_OFFS     = 4'h0;
    localparam logic [3:0]  DT_PRI_OFFS    = 4'h4;
    localparam logic [3:0]  DT_ALT_OFFS    = 4'h8;
    localparam logic [3:0]  TRIG_CTRL_OFFS = 4'hC;
    localparam logic [3:0]  PWM_CTRL_OFFS  = 4'h0;
    localparam logic [15:0] PHASE_MASK     = 16'hFFFC;
    localparam logic [15:0] PHASE_ITB_MASK = 16'hFFF0;
    localparam logic [15:0] DT_MASK        = 16'h3FFC;
    localparam logic [15:0] TRIG_MASK      = 16'hE03F;
    localparam logic [15:0] PWM_CTRL_MASK  = 16'h0007;
    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam int          DIV_LSB        = 13;
    localparam int          DIV_MSB        = 15;
    localparam int          START_MSB      = 5;
    localparam int          ITB_BIT        = 0;
    localparam int          DTC_LSB        = 1;
    localparam int          DTC_MSB        = 2;
    localparam int          AXI_AW         = 5;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    localparam logic [4:0]  CTRL_BYTE_ADDR = 5'h10;
    typedef enum logic [1:0] {
        DT_POSITIVE = 2'b00,
        DT_NEGATIVE = 2'b01,
        DT_DISABLED = 2'b10,
        DT_RESERVED = 2'b11
    } dead_time_mode_t;
endpackage : pwm_cfg_pkg

// ==== core/trigger_postscaler.sv ====
// Trigger postscaler: start match on roll counter, then divide events
`timescale 1ns/1ns
module trigger_postscaler
    import pwm_cfg_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic [2:0] divideSelect,
    input  wire logic [5:0] startMatch,
    input  wire logic [5:0] rollCount,
    input  wire logic       trigEvent,
    output logic            trigOut,
    output logic            armed
);
    logic       armed_q;
    logic       armed_d;
    logic [2:0] count_q;
    logic [2:0] count_d;
    logic       out_q;
    logic       out_d;
    wire        startHit  = (rollCount == startMatch);
    wire        countable = armed_q && trigEvent;
    wire        lastEvent = (count_q == divideSelect);

    assign armed_d = armed_q | startHit;                                 // [R6]
    assign count_d = !countable ? count_q
                   : (lastEvent ? 3'h0 : 3'(count_q + 3'h1));            // [R7]
    assign out_d   = countable && lastEvent;                             // [R5]

    always_ff @(posedge core_clk) begin
        if (srst) begin
            armed_q <= 1'b0;
            count_q <= 3'h0;
            out_q   <= 1'b0;
        end else begin
            armed_q <= armed_d;
            count_q <= count_d;
            out_q   <= out_d;
        end
    end

    assign trigOut = out_q;
    assign armed   = armed_q;

    chk_no_trig_unarmed: assert property (@(posedge core_clk) disable iff (srst) // [R6]
        !armed_q |=> !out_q)
        else $error("trigger emitted before start match");
    chk_div_one_each: assert property (@(posedge core_clk) disable iff (srst) // [R5]
        (armed_q && trigEvent && divideSelect == 3'h0) |=> out_q)
        else $error("divide-by-one missed an event");
    chk_count_wrap: assert property (@(posedge core_clk) disable iff (srst) // [R7]
        out_q |-> count_q == 3'h0)
        else $error("count not restarted after trigger");
    chk_arm_sticky: assert property (@(posedge core_clk) disable iff (srst) // [R6]
        (rollCount == startMatch) |=> armed_q [*2])
        else $error("postscaler not armed after match");
    cov_trig_div8: cover property (@(posedge core_clk)
        out_q && divideSelect == 3'h7);
endmodule : trigger_postscaler

// ==== core/pwm_cfg_regs.sv ====
// AXI4-Lite config registers for one PWM generator with trigger postscaler
//
// Functional notes
// R1 - Phase register keeps bits 15..2; as period in independent mode bits 3..2 are ignored.
// R2 - Primary dead time is an unsigned 12-bit value in bits 13..2 fed to the dead-time unit.
// R3 - Dead-time bits 15..14 and 1..0 read zero and ignore writes.
// R4 - Alternate dead time is a second 12-bit value in bits 13..2, other bits read zero.
// R5 - Divider code N in bits 15..13 emits a trigger every (N+1)th trigger event.
// R6 - Postscaler does not count until roll counter equals the start field in bits 5..0.
// R7 - Postscaler emits one trigger when its count hits the ratio, then restarts at zero.
// R8 - Independent select set makes phase the period; clear uses the primary time base.
// R9 - Dead-time control 00 positive, 01 negative, 10 disabled, 11 reserved.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module pwm_cfg_regs
    import pwm_cfg_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [5:0]        rollCount,
    input  wire logic              trigEvent,
    output logic [15:0]            phaseValue,
    output logic [15:0]            periodValue,
    output logic                   independentPeriodSelect,
    output logic [11:0]            primaryDeadTimeValue,
    output logic [11:0]            alternateDeadTimeValue,
    output logic [1:0]             deadTimeControl,
    output logic                   trigOut
);
    logic [15:0] phase_q, dtPri_q, dtAlt_q, trig_q, ctrl_q;
    logic [15:0] phase_d, dtPri_d, dtAlt_d, trig_d, ctrl_d;
    logic [AXI_AW-1:0] awAddr_q;
    logic        awHave_q, wHave_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        bValid_q, rValid_q;
    logic [1:0]  bResp_q, rResp_q;
    logic [31:0] rData_q;
    logic [15:0] periodOut_q, phaseOut_q;
    logic        itbOut_q;
    logic [11:0] dtPriOut_q, dtAltOut_q;
    logic [1:0]  dtcOut_q;
    logic        postArmed;

    // Write channel capture, either order
    wire awTake  = s_axi_awvalid && !awHave_q;
    wire wTake   = s_axi_wvalid && !wHave_q;
    wire doWrite = awHave_q && wHave_q && !bValid_q;
    wire [3:0] wrIdx  = {awAddr_q[AXI_AW-2:2], 2'b00};
    wire       wrCtrl = (awAddr_q == CTRL_BYTE_ADDR);
    wire       wrLow  = (awAddr_q[AXI_AW-1] == 1'b0);
    wire [15:0] wrByteMask = {{8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    wire [15:0] wrVal      = wData_q[15:0];
    wire wrPhase = doWrite && wrLow && wrIdx == PHASE_OFFS;
    wire wrDtPri = doWrite && wrLow && wrIdx == DT_PRI_OFFS;
    wire wrDtAlt = doWrite && wrLow && wrIdx == DT_ALT_OFFS;
    wire wrTrig  = doWrite && wrLow && wrIdx == TRIG_CTRL_OFFS;
    wire wrCtl   = doWrite && wrCtrl;
    wire wrHit   = wrPhase | wrDtPri | wrDtAlt | wrTrig | wrCtl;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [15:0] bm,
                                          input logic [15:0] keep);
        merge = ((old & ~bm) | (val & bm)) & keep;
    endfunction : merge

    assign phase_d = wrPhase ? merge(phase_q, wrVal, wrByteMask, PHASE_MASK)
                             : phase_q;                                  // [R1]
    assign dtPri_d = wrDtPri ? merge(dtPri_q, wrVal, wrByteMask, DT_MASK)
                             : dtPri_q;                                  // [R2] [R3]
    assign dtAlt_d = wrDtAlt ? merge(dtAlt_q, wrVal, wrByteMask, DT_MASK)
                             : dtAlt_q;                                  // [R4]
    assign trig_d  = wrTrig ? merge(trig_q, wrVal, wrByteMask, TRIG_MASK)
                            : trig_q;                                    // [R5] [R6]
    assign ctrl_d  = wrCtl ? merge(ctrl_q, wrVal, wrByteMask, PWM_CTRL_MASK)
                           : ctrl_q;                                     // [R8] [R9]

    // Read decode
    wire arTake = s_axi_arvalid && !rValid_q;
    wire [3:0] rdIdx  = {s_axi_araddr[AXI_AW-2:2], 2'b00};
    wire       rdLow  = (s_axi_araddr[AXI_AW-1] == 1'b0);
    wire       rdCtrl = (s_axi_araddr == CTRL_BYTE_ADDR);
    wire [15:0] rdMux =
        rdCtrl ? (ctrl_q | {postArmed, 15'h0000})
      : !rdLow ? 16'h0000
      : rdIdx == PHASE_OFFS ? phase_q
      : rdIdx == DT_PRI_OFFS ? dtPri_q                                   // [R3]
      : rdIdx == DT_ALT_OFFS ? dtAlt_q
      : trig_q;
    wire rdHit = rdLow || rdCtrl;

    // Derived outputs toward the generator
    wire itbSel = ctrl_q[ITB_BIT];
    wire [15:0] periodSel = itbSel ? (phase_q & PHASE_ITB_MASK)
                                   : 16'h0000;                           // [R1] [R8]
    wire [1:0] dtcSel = ctrl_q[DTC_MSB:DTC_LSB];
    wire dtDisabled = (dtcSel == DT_DISABLED) || (dtcSel == DT_RESERVED);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            phase_q <= REG_RESET;
            dtPri_q <= REG_RESET;
            dtAlt_q <= REG_RESET;
            trig_q  <= REG_RESET;
            ctrl_q  <= REG_RESET;
        end else begin
            phase_q <= phase_d;
            dtPri_q <= dtPri_d;
            dtAlt_q <= dtAlt_d;
            trig_q  <= trig_d;
            ctrl_q  <= ctrl_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            awAddr_q <= '0;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q  <= RESP_OKAY;
        end else begin
            if (awTake) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                bValid_q <= 1'b1;
                bResp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (bValid_q && s_axi_bready) begin
                bValid_q <= 1'b0;
                awHave_q <= 1'b0;
                wHave_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rValid_q <= 1'b0;
            rData_q  <= 32'h0000_0000;
            rResp_q  <= RESP_OKAY;
        end else if (arTake) begin
            rValid_q <= 1'b1;
            rData_q  <= {16'h0000, rdMux};
            rResp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            phaseOut_q  <= 16'h0000;
            periodOut_q <= 16'h0000;
            itbOut_q    <= 1'b0;
            dtPriOut_q  <= 12'h000;
            dtAltOut_q  <= 12'h000;
            dtcOut_q    <= 2'b00;
        end else begin
            phaseOut_q  <= itbSel ? 16'h0000 : phase_q;                  // [R8]
            periodOut_q <= periodSel;
            itbOut_q    <= itbSel;
            dtPriOut_q  <= dtDisabled ? 12'h000 : dtPri_q[13:2];         // [R2] [R9]
            dtAltOut_q  <= dtDisabled ? 12'h000 : dtAlt_q[13:2];         // [R4] [R9]
            dtcOut_q    <= dtcSel;
        end
    end

    trigger_postscaler u_post (
        .core_clk     (core_clk),
        .srst         (srst),
        .divideSelect (trig_q[DIV_MSB:DIV_LSB]),
        .startMatch   (trig_q[START_MSB:0]),
        .rollCount    (rollCount),
        .trigEvent    (trigEvent),
        .trigOut      (trigOut),
        .armed        (postArmed)
    );

    assign s_axi_awready = !awHave_q;
    assign s_axi_wready  = !wHave_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
    assign phaseValue             = phaseOut_q;
    assign periodValue            = periodOut_q;
    assign independentPeriodSelect = itbOut_q;
    assign primaryDeadTimeValue   = dtPriOut_q;
    assign alternateDeadTimeValue = dtAltOut_q;
    assign deadTimeControl        = dtcOut_q;

    chk_phase_low_zero: assert property (@(posedge core_clk) disable iff (srst) // [R1]
        phase_q[1:0] == 2'b00)
        else $error("phase low bits not zero");
    chk_period_drop_bits: assert property (@(posedge core_clk) disable iff (srst) // [R1]
        itbSel |=> periodValue[3:0] == 4'h0 && periodValue[15:4] == $past(phase_q[15:4]))
        else $error("period not phase with bits 3..0 cleared");
    chk_dt_unimpl: assert property (@(posedge core_clk) disable iff (srst) // [R3]
        dtPri_q[15:14] == 2'b00 && dtPri_q[1:0] == 2'b00)
        else $error("dead-time unimplemented bits set");
    chk_alt_unimpl: assert property (@(posedge core_clk) disable iff (srst) // [R4]
        (dtAlt_q & ~DT_MASK) == 16'h0000)
        else $error("alternate dead-time spare bits set");
    chk_dt_value: assert property (@(posedge core_clk) disable iff (srst) // [R2]
        (dtcSel == DT_POSITIVE) |=> primaryDeadTimeValue == $past(dtPri_q[13:2]))
        else $error("primary dead time not passed on");
    chk_dt_disabled: assert property (@(posedge core_clk) disable iff (srst) // [R9]
        (dtcSel == DT_DISABLED) |=> primaryDeadTimeValue == 12'h000)
        else $error("dead time not disabled");
    chk_itb_primary: assert property (@(posedge core_clk) disable iff (srst) // [R8]
        !itbSel |=> periodValue == 16'h0000 && phaseValue == $past(phase_q))
        else $error("primary time base mode wrong");
    chk_trig_unimpl: assert property (@(posedge core_clk) disable iff (srst) // [R5]
        trig_q[12:6] == 7'h00)
        else $error("trigger control spare bits set");
    cov_write_phase: cover property (@(posedge core_clk) wrPhase);
    cov_read_back: cover property (@(posedge core_clk) rValid_q && s_axi_rready);
    cov_itb_mode: cover property (@(posedge core_clk) itbSel && trigOut);
endmodule : pwm_cfg_regs

// ==== tb/pwm_far_side_model.sv ====
// Far-side model: roll counter, trigger events, trigger pulse counter
`timescale 1ns/1ns
module pwm_far_side_model (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       rollRun,
    input  wire logic [7:0] eventBudget,
    input  wire logic       trigOut,
    output logic [5:0]      rollCount,
    output logic            trigEvent,
    output logic [7:0]      eventsSent,
    output logic [7:0]      trigPulses
);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            // Roll counter parks at its top value, away from start 0
            rollCount <= 6'h3F;
            trigEvent <= 1'b0;
            eventsSent <= 8'h00;
            trigPulses <= 8'h00;
        end else begin
            if (rollRun) begin
                rollCount <= rollCount + 6'h01;
            end
            // Events on every other cycle, until the budget is spent
            trigEvent <= 1'b0;
            if (!trigEvent && eventsSent != eventBudget) begin
                trigEvent <= 1'b1;
                eventsSent <= eventsSent + 8'h01;
            end
            if (trigOut) begin
                trigPulses <= trigPulses + 8'h01;
            end
        end
    end
endmodule : pwm_far_side_model

// ==== tb/pwm_phase_deadtime_trigger_regs_tb.sv ====
// Testbench for the PWM generator config registers
`timescale 1ns/1ns
module pwm_phase_deadtime_trigger_regs_tb;
    import pwm_cfg_pkg::*;
    logic              core_clk = 1'b0;
    logic              srst = 1'b1;
    logic [AXI_AW-1:0] awAddr = '0;
    logic [AXI_AW-1:0] arAddr = '0;
    logic [31:0]       wData = '0;
    logic              awValid = 1'b0;
    logic              wValid = 1'b0;
    logic              bReady = 1'b0;
    logic              arValid = 1'b0;
    logic              rReady = 1'b0;
    logic              rollRun = 1'b0;
    logic [7:0]        budget = 8'h00;
    logic [31:0]       rd;
    logic [1:0]        rsp;
    wire logic         awReady, wReady, bValid, arReady, rValid;
    wire logic         trigEvent, trigOut, itbSel;
    wire logic [1:0]   bResp, rResp, dtCtl;
    wire logic [31:0]  rData;
    wire logic [5:0]   rollCount;
    wire logic [15:0]  phaseVal, periodVal;
    wire logic [11:0]  dtPri, dtAlt;
    wire logic [7:0]   sent, pulses;
    int                numErrors = 0;
    int                checked = 0;
    int                cycles = 0;

    pwm_cfg_regs i_dut (.core_clk(core_clk), .srst(srst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .rollCount(rollCount), .trigEvent(trigEvent), .phaseValue(phaseVal),
        .periodValue(periodVal), .independentPeriodSelect(itbSel),
        .primaryDeadTimeValue(dtPri), .alternateDeadTimeValue(dtAlt),
        .deadTimeControl(dtCtl), .trigOut(trigOut));
    pwm_far_side_model i_far (.core_clk(core_clk), .srst(srst),
        .rollRun(rollRun), .eventBudget(budget), .trigOut(trigOut),
        .rollCount(rollCount), .trigEvent(trigEvent), .eventsSent(sent),
        .trigPulses(pulses));

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            numErrors++;
            closeOut();
        end
    end

    task automatic check(input string nm, input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic axiWrite(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awAddr <= a;
        awValid <= 1'b1;
        wData <= d;
        wValid <= 1'b1;
        bReady <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid) begin
                rsp = bResp;
                bReady <= 1'b0;
                break;
            end
        end
    endtask : axiWrite
    task automatic axiRead(input logic [4:0] a);
        @(posedge core_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid) begin
                rd = rData;
                rsp = rResp;
                rReady <= 1'b0;
                break;
            end
        end
    endtask : axiRead
    task automatic resetDut;
        @(posedge core_clk);
        srst <= 1'b1;
        budget <= 8'h00;
        rollRun <= 1'b0;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
    endtask : resetDut
    task automatic waitSent;
        @(posedge core_clk);
        for (int k = 0; k < 200 && sent !== budget; k++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
    endtask : waitSent

    task automatic testReset;
        resetDut();
        for (int i = 0; i < 5; i++) begin
            axiRead(5'(i * 4));
            // Parked roll count misses start field 0, so not armed
            check("reset", {rsp, rd}, 64'h0);
        end
        $display("reset test done");
    endtask : testReset
    task automatic testMasks;
        logic [15:0] m [4];
        m = '{PHASE_MASK, DT_MASK, DT_MASK, TRIG_MASK};
        for (int i = 0; i < 4; i++) begin
            axiWrite(5'(i * 4), 32'hFFFF_FFFF);
            axiRead(5'(i * 4));
            check("mask", {rsp, rd}, {RESP_OKAY, 16'h0, m[i]});
        end
        check("outs", {phaseVal, periodVal, dtPri, dtAlt},
              {16'hFFFC, 16'h0, 12'hFFF, 12'hFFF});
        $display("mask test done");
    endtask : testMasks
    task automatic testModes;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            axiWrite(CTRL_BYTE_ADDR, {29'h0, c});
            axiRead(CTRL_BYTE_ADDR);
            check("ctrl", rd, {16'h0, 13'h1000, c});
            check("modes", {itbSel, dtCtl, phaseVal, periodVal, dtPri, dtAlt},
                  {c[0], c[2:1], c[0] ? 32'h0000_FFF0 : 32'hFFFC_0000,
                   c[2] ? 24'h0 : 24'hFFF_FFF});
        end
        $display("mode test done");
    endtask : testModes
    task automatic testUnmapped;
        axiWrite(5'h14, 32'hFFFF_FFFF);
        check("unmapped wr", rsp, RESP_SLVERR);
        axiRead(5'h1C);
        check("unmapped rd", {rsp, rd}, {RESP_SLVERR, 32'h0});
        axiWrite(5'(PHASE_OFFS), 32'h0000_1234);
        axiRead(5'(PHASE_OFFS));
        check("phase", rd, 32'h0000_1234);
        $display("unmapped test done");
    endtask : testUnmapped
    task automatic testTrigger(input logic [2:0] n);
        resetDut();
        axiWrite(5'(TRIG_CTRL_OFFS), {16'h0, n, 7'h0, 3'h1, n});
        budget <= 8'h03;
        waitSent();
        check("early pulses", pulses, 8'h00);
        rollRun <= 1'b1;
        rd = '0;
        for (int k = 0; k < 40 && rd[15] !== 1'b1; k++) axiRead(CTRL_BYTE_ADDR);
        check("armed", rd[15], 1'b1);
        budget <= budget + 8'(3 * n + 2);
        waitSent();
        check("pulses", pulses, 8'h02);
        budget <= budget + 8'h01;
        waitSent();
        check("restart", pulses, 8'h03);
        $display("trigger test done for divider %0d", n);
    endtask : testTrigger

    task automatic closeOut;
        $display("checks %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : closeOut

    initial begin
        testReset();
        testMasks();
        testModes();
        testUnmapped();
        for (int n = 0; n < 8; n++) testTrigger(3'(n));
        closeOut();
    end
endmodule : pwm_phase_deadtime_trigger_regs_tb
